// file: inc/oag_pkg.sv
// Package of types and constants for the operand address generator.
package oag_pkg;

  // ==========================================================================
  // Modes and categories
  // ==========================================================================
  // Addressing modes; bit-test branches get their own code because they
  // combine a direct operand with a relative target.
  typedef enum logic [3:0] {
    MODE_INH, MODE_IMM, MODE_DIR, MODE_EXT,
    MODE_IX, MODE_IX1, MODE_IX2, MODE_REL, MODE_BIT_BRANCH
  } mode_e;

  // The five instruction categories.
  typedef enum logic [2:0] {
    CAT_REG_MEM, CAT_RMW, CAT_JUMP_BRANCH, CAT_BIT_MANIP, CAT_CONTROL
  } category_e;

  // ==========================================================================
  // Opcode map fields
  // ==========================================================================
  localparam logic [3:0] ROW_BIT_BRANCH = 4'h0; // Bit test and branch.
  localparam logic [3:0] ROW_BIT_SET    = 4'h1; // Bit set and clear.
  localparam logic [3:0] ROW_BRANCH     = 4'h2; // Relative branches.
  localparam logic [3:0] ROW_RMW_DIR    = 4'h3; // Read-modify-write, direct.
  localparam logic [3:0] ROW_RMW_ACC    = 4'h4; // On the accumulator.
  localparam logic [3:0] ROW_RMW_IDX    = 4'h5; // On the index register.
  localparam logic [3:0] ROW_RMW_IX1    = 4'h6; // Indexed 8-bit offset.
  localparam logic [3:0] ROW_RMW_IX     = 4'h7; // Indexed, no offset.
  localparam logic [3:0] ROW_CTRL_LO    = 4'h8; // Control, first row.
  localparam logic [3:0] ROW_CTRL_HI    = 4'h9; // Control, second row.
  localparam logic [3:0] ROW_IMM        = 4'hA; // Register/memory rows.
  localparam logic [3:0] ROW_DIR        = 4'hB;
  localparam logic [3:0] ROW_EXT        = 4'hC;
  localparam logic [3:0] ROW_IX2        = 4'hD;
  localparam logic [3:0] ROW_IX1        = 4'hE;
  localparam logic [3:0] ROW_IX         = 4'hF;
  localparam logic [3:0] COL_TEST_NZ    = 4'hD; // test_negative_zero column.
  localparam logic [3:0] COL_JUMP       = 4'hC; // Jump column.
  localparam logic [3:0] COL_SUBR       = 4'hD; // Subroutine call column.
  localparam int         BIT_SEL_LSB    = 1;    // Bit number field of opcode.
  localparam int         BIT_POL_POS    = 0;    // 1 = branch_if_bit_clear.

  // ==========================================================================
  // Lengths and address constants
  // ==========================================================================
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [7:0] PAGE_ZERO = 8'h00;  // High byte of page-zero modes.
  localparam logic [15:0] IX1_TOP  = 16'h01FE; // Highest 8-bit-offset reach.
  localparam logic [15:0] PC_RESET = 16'h0000;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  // One instruction as fetched, with the CPU state the address needs.
  typedef struct packed {
    logic [7:0]  opcode;    // First byte.
    logic [7:0]  byte1;     // Byte after the opcode.
    logic [7:0]  byte2;     // Third byte.
    logic [7:0]  index;     // Index register.
    logic [15:0] pc;        // Address of the opcode.
    logic        cond;      // Branch condition from the CPU flags.
    logic [7:0]  bit_data;  // Operand byte for bit-test branches.
  } decode_req_s;

  // Decoded instruction.
  typedef struct packed {
    mode_e       mode;
    category_e   category;
    logic [1:0]  length;
    logic        has_addr;     // operand_addr is meaningful.
    logic [15:0] operand_addr;
    logic        has_imm;      // imm_data is meaningful.
    logic [7:0]  imm_data;
    logic [15:0] next_pc;      // Sequential successor.
    logic [15:0] branch_pc;    // Program counter after this instruction.
    logic        take_branch;
    logic        carry_load;   // Carry flag is to be loaded.
    logic        carry;
    logic        writeback;    // Read-modify-write stores a result.
  } result_s;

endpackage

// file: src/opcode_classifier.sv
// Opcode classifier: addressing mode, category, length and write-back.
`timescale 1ns/1ps
module opcode_classifier (
  input  wire logic [7:0]         opcode_in,
  output oag_pkg::mode_e          mode_out,
  output oag_pkg::category_e      category_out,
  output logic [1:0]              length_out,
  output logic                    writeback_out
);

  // ==========================================================================
  // Field split
  // ==========================================================================
  wire [3:0] row = opcode_in[7:4]; // Selects mode and category.
  wire [3:0] col = opcode_in[3:0]; // Selects the operation.

  // ==========================================================================
  // Mode and category
  // ==========================================================================
  // Pure combinational decode so the top can register all results together.
  always_comb begin
    mode_out      = oag_pkg::MODE_INH;
    category_out  = oag_pkg::CAT_CONTROL;
    writeback_out = 1'b0;
    case (row)
      oag_pkg::ROW_BIT_BRANCH: begin
        mode_out     = oag_pkg::MODE_BIT_BRANCH;
        category_out = oag_pkg::CAT_BIT_MANIP;
      end
      oag_pkg::ROW_BIT_SET: begin
        mode_out      = oag_pkg::MODE_DIR;
        category_out  = oag_pkg::CAT_BIT_MANIP;
        writeback_out = 1'b1;
      end
      oag_pkg::ROW_BRANCH: begin
        mode_out     = oag_pkg::MODE_REL;
        category_out = oag_pkg::CAT_JUMP_BRANCH;
      end
      oag_pkg::ROW_RMW_DIR, oag_pkg::ROW_RMW_ACC, oag_pkg::ROW_RMW_IDX,
      oag_pkg::ROW_RMW_IX1, oag_pkg::ROW_RMW_IX: begin
        category_out  = oag_pkg::CAT_RMW;
        writeback_out = (col != oag_pkg::COL_TEST_NZ);
        if (row == oag_pkg::ROW_RMW_DIR) begin
          mode_out = oag_pkg::MODE_DIR;
        end else if (row == oag_pkg::ROW_RMW_IX1) begin
          mode_out = oag_pkg::MODE_IX1;
        end else if (row == oag_pkg::ROW_RMW_IX) begin
          mode_out = oag_pkg::MODE_IX;
        end else begin
          mode_out = oag_pkg::MODE_INH;
        end
      end
      oag_pkg::ROW_CTRL_LO, oag_pkg::ROW_CTRL_HI: begin
        mode_out     = oag_pkg::MODE_INH;
        category_out = oag_pkg::CAT_CONTROL;
      end
      default: begin
        // Register/memory rows; jump columns reuse the row's addressing mode, save the subroutine column of the immediate row, which is relative.
        category_out = (col == oag_pkg::COL_JUMP || col == oag_pkg::COL_SUBR)
                       ? oag_pkg::CAT_JUMP_BRANCH : oag_pkg::CAT_REG_MEM;
        if (row == oag_pkg::ROW_IMM) begin
          mode_out = (col == oag_pkg::COL_SUBR) ? oag_pkg::MODE_REL
                                                : oag_pkg::MODE_IMM;
        end else if (row == oag_pkg::ROW_DIR) begin
          mode_out = oag_pkg::MODE_DIR;
        end else if (row == oag_pkg::ROW_EXT) begin
          mode_out = oag_pkg::MODE_EXT;
        end else if (row == oag_pkg::ROW_IX2) begin
          mode_out = oag_pkg::MODE_IX2;
        end else if (row == oag_pkg::ROW_IX1) begin
          mode_out = oag_pkg::MODE_IX1;
        end else begin
          mode_out = oag_pkg::MODE_IX;
        end
      end
    endcase
  end

  // ==========================================================================
  // Length
  // ==========================================================================
  // Length follows from the mode alone.
  always_comb begin
    case (mode_out)
      oag_pkg::MODE_INH, oag_pkg::MODE_IX:   length_out = oag_pkg::LEN_ONE;
      oag_pkg::MODE_EXT, oag_pkg::MODE_IX2,
      oag_pkg::MODE_BIT_BRANCH:              length_out = oag_pkg::LEN_THREE;
      default:                               length_out = oag_pkg::LEN_TWO;
    endcase
  end

endmodule

// file: src/operand_address_generator.sv
// Operand address generator: decodes an instruction and forms its addresses.
`timescale 1ns/1ps
module operand_address_generator (
  input  wire logic                clk_in,
  input  wire logic                rst_b_in,
  input  wire logic                req_valid_in,
  input  wire oag_pkg::decode_req_s req_in,
  output logic                     valid_out,
  output oag_pkg::result_s         result_out
);

  // ==========================================================================
  // Classification
  // ==========================================================================
  oag_pkg::mode_e     cls_mode;      // Mode of the offered opcode.
  oag_pkg::category_e cls_category;  // Category of the offered opcode.
  logic [1:0]         cls_length;    // Byte count of the offered opcode.
  logic               cls_writeback; // Whether a result is stored back.

  opcode_classifier u_classifier (
    .opcode_in     (req_in.opcode),
    .mode_out      (cls_mode),
    .category_out  (cls_category),
    .length_out    (cls_length),
    .writeback_out (cls_writeback)
  );

  // ==========================================================================
  // Address arithmetic
  // ==========================================================================
  // Page-zero forms share one high byte of zero.
  wire [15:0] addr_dir = {oag_pkg::PAGE_ZERO, req_in.byte1};
  wire [15:0] addr_ext = {req_in.byte1, req_in.byte2};
  wire [15:0] addr_ix  = {oag_pkg::PAGE_ZERO, req_in.index};
  // Unsigned 9-bit sum; carry lands in bit 8, so the reach ends at 510.
  wire [15:0] addr_ix1 = {7'h00, {1'b0, req_in.index} + {1'b0, req_in.byte1}};
  // The carry out of bit 15 is dropped on purpose: the space wraps.
  wire [15:0] addr_ix2 = 16'(addr_ix + addr_ext);

  // Successor address, measured from the opcode address by the length.
  wire [15:0] next_pc  = 16'(req_in.pc + {14'h0000, cls_length});
  // Bit-test branches carry the offset in the third byte.
  wire [7:0]  rel_off  = (cls_mode == oag_pkg::MODE_BIT_BRANCH)
                         ? req_in.byte2 : req_in.byte1;
  wire [15:0] rel_dest = 16'(next_pc + {{8{rel_off[7]}}, rel_off});

  // ==========================================================================
  // Bit test
  // ==========================================================================
  // Tested bit number and polarity come from the opcode itself.
  wire [2:0] bit_sel    = req_in.opcode[oag_pkg::BIT_SEL_LSB +: 3];
  wire       bit_value  = req_in.bit_data[bit_sel];
  wire       bit_clr    = req_in.opcode[oag_pkg::BIT_POL_POS];
  wire       bit_branch = (cls_mode == oag_pkg::MODE_BIT_BRANCH);
  wire       bit_true   = bit_clr ? ~bit_value : bit_value;

  // ==========================================================================
  // Operand address select
  // ==========================================================================
  logic [15:0] sel_addr; // Effective operand address.
  logic        sel_has;  // A memory operand exists.

  // Inherent, immediate and relative forms name no memory operand.
  always_comb begin
    sel_addr = 16'h0000;
    sel_has  = 1'b1;
    case (cls_mode)
      oag_pkg::MODE_DIR, oag_pkg::MODE_BIT_BRANCH: sel_addr = addr_dir;
      oag_pkg::MODE_EXT: sel_addr = addr_ext;
      oag_pkg::MODE_IX:  sel_addr = addr_ix;
      oag_pkg::MODE_IX1: sel_addr = addr_ix1;
      oag_pkg::MODE_IX2: sel_addr = addr_ix2;
      default:           sel_has  = 1'b0;
    endcase
  end

  // ==========================================================================
  // Branch resolution
  // ==========================================================================
  // Jumps through memory operands take the operand address as target.
  wire is_rel  = (cls_mode == oag_pkg::MODE_REL) || bit_branch;
  wire rel_go  = bit_branch ? bit_true : req_in.cond;
  wire is_jump = (cls_category == oag_pkg::CAT_JUMP_BRANCH) && !is_rel;
  wire take    = is_rel ? rel_go : is_jump;
  wire [15:0] dest = !take ? next_pc : (is_rel ? rel_dest : sel_addr);

  // ==========================================================================
  // Next result
  // ==========================================================================
  oag_pkg::result_s next_result; // Result assembled from the request.

  always_comb begin
    next_result              = '0;
    next_result.mode         = cls_mode;
    next_result.category     = cls_category;
    next_result.length       = cls_length;
    next_result.has_addr     = sel_has;
    next_result.operand_addr = sel_addr;
    next_result.has_imm      = (cls_mode == oag_pkg::MODE_IMM);
    next_result.imm_data     = req_in.byte1;
    next_result.next_pc      = next_pc;
    next_result.branch_pc    = dest;
    next_result.take_branch  = take;
    next_result.carry_load   = bit_branch;
    next_result.carry        = bit_value;
    next_result.writeback    = cls_writeback;
  end

  // ==========================================================================
  // Output registers
  // ==========================================================================
  // One cycle of latency keeps every output on a flip-flop; the result
  // holds until the next request so the CPU may sample it late.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      valid_out  <= 1'b0;
      result_out <= '0;
    end else begin
      valid_out <= req_valid_in;
      if (req_valid_in) begin
        result_out <= next_result;
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  // Each check looks one edge after the taking edge, where the result stands; a_valid_follows also looks one edge further.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // Request-side sequences, so that each property reads as cause and effect.
  sequence s_req(oag_pkg::mode_e m);
    req_valid_in && cls_mode == m;
  endsequence

  sequence s_bit_req;
    req_valid_in && bit_branch;
  endsequence

  a_inh_no_addr: assert property (s_req(oag_pkg::MODE_INH) |=>
    result_out.length == 2'h1 && !result_out.has_addr)
    else $error("inherent decode has address or wrong length");

  a_imm_data_pass: assert property (s_req(oag_pkg::MODE_IMM) |=>
    result_out.imm_data == $past(req_in.byte1) && !result_out.has_addr
    && result_out.length == 2'h2)
    else $error("immediate data or length wrong");

  a_dir_page_zero: assert property (s_req(oag_pkg::MODE_DIR) |=>
    result_out.operand_addr == {8'h00, $past(req_in.byte1)})
    else $error("direct address wrong");

  a_ext_full_addr: assert property (s_req(oag_pkg::MODE_EXT) |=>
    result_out.operand_addr == {$past(req_in.byte1), $past(req_in.byte2)}
    && result_out.length == 2'h3)
    else $error("extended address wrong");

  a_ix_page_zero: assert property (s_req(oag_pkg::MODE_IX) |=>
    result_out.operand_addr == {8'h00, $past(req_in.index)}
    && result_out.length == 2'h1)
    else $error("indexed no-offset address wrong");

  a_ix1_reach: assert property (s_req(oag_pkg::MODE_IX1) |=>
    result_out.operand_addr <= 16'h01FE && result_out.operand_addr ==
    16'($past(req_in.index)) + 16'($past(req_in.byte1)))
    else $error("8-bit offset address wrong");

  a_ix2_wrap_sum: assert property (s_req(oag_pkg::MODE_IX2) |=>
    result_out.operand_addr == 16'($past(req_in.index) + {$past(req_in.byte1),
    $past(req_in.byte2)}))
    else $error("16-bit offset address wrong");

  a_rel_target: assert property (s_req(oag_pkg::MODE_REL) |=>
    result_out.take_branch == $past(req_in.cond) && result_out.branch_pc ==
    (result_out.take_branch ? 16'(result_out.next_pc
    + {{8{$past(req_in.byte1[7])}}, $past(req_in.byte1)}) : result_out.next_pc))
    else $error("relative destination wrong");

  a_bit_carry_copy: assert property (s_bit_req |=>
    result_out.carry_load && result_out.carry == $past(bit_value)
    && result_out.length == 2'h3 && result_out.operand_addr[15:8] == 8'h00)
    else $error("bit-test branch decode wrong");

  // Outcome of a bit test: taken when the tested bit differs from the polarity bit.
  sequence s_bit_answer;
    result_out.take_branch == ($past(req_in.bit_data[req_in.opcode[oag_pkg::BIT_SEL_LSB +: 3]])
    ^ $past(req_in.opcode[oag_pkg::BIT_POL_POS]));
  endsequence

  // The destination counts from the byte after all three bytes.
  a_bit_dest: assert property (s_bit_req |=> s_bit_answer ##0
    result_out.branch_pc == (result_out.take_branch ? 16'(result_out.next_pc
    + {{8{$past(req_in.byte2[7])}}, $past(req_in.byte2)}) : result_out.next_pc))
    else $error("bit-test branch destination wrong");

  a_tst_no_store: assert property (req_valid_in && cls_category ==
    oag_pkg::CAT_RMW && req_in.opcode[3:0] == 4'hD |=> !result_out.writeback)
    else $error("negative-zero test stores a result");

  // Every other read-modify-write opcode stores its result.
  a_rmw_store: assert property (req_valid_in
    && req_in.opcode[7:4] >= oag_pkg::ROW_RMW_DIR && req_in.opcode[7:4] <= oag_pkg::ROW_RMW_IX
    && req_in.opcode[3:0] != oag_pkg::COL_TEST_NZ
    |=> result_out.writeback && result_out.category == oag_pkg::CAT_RMW)
    else $error("read-modify-write does not store");

  // Both bit rows sort into the bit manipulation category.
  a_cat_bit_rows: assert property (req_valid_in
    && req_in.opcode[7:4] <= oag_pkg::ROW_BIT_SET
    |=> result_out.category == oag_pkg::CAT_BIT_MANIP)
    else $error("bit row in wrong category");

  // The sequential successor is the opcode address plus the length.
  a_next_pc: assert property (req_valid_in |=>
    result_out.next_pc == 16'($past(req_in.pc) + {14'h0, result_out.length}))
    else $error("sequential successor wrong");

  a_valid_follows: assert property (req_valid_in |=> valid_out ##1
    (valid_out == $past(req_valid_in)))
    else $error("valid does not follow request");

endmodule

// file: test/page_zero_memory.sv
// Memory model answering page-zero reads for bit-test branches.
`timescale 1ns/1ps
module page_zero_memory (
  input  wire logic [15:0] addr_in,
  output logic      [7:0]  data_out
);
  // ==========================================================================
  // Read path
  // ==========================================================================
  // Each byte is a pattern of its own address.
  // A misrouted address then reads a wrong bit.
  assign data_out = addr_in[7:0] ^ 8'hA5;
endmodule

// file: test/testbench.sv
// Self-checking testbench for the operand address generator.
`timescale 1ns/1ps
module testbench;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic                 clk_in;       // Clock, 5 ns period.
  logic                 rst_b_in;     // Synchronous reset, active low.
  logic                 req_valid_in; // Request strobe.
  oag_pkg::decode_req_s req_in;       // Instruction to decode.
  logic                 valid_out;    // Answer strobe.
  oag_pkg::result_s     result_out;   // Decoded result.
  logic [15:0]          look_addr;    // Address asked of the memory.
  logic [7:0]           look_data;    // Byte the memory returns.
  int                   num_errors;   // Mismatches seen.
  int                   num_checks;   // Comparisons made.

  operand_address_generator i_operand_address_generator (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .req_valid_in(req_valid_in),
    .req_in      (req_in),
    .valid_out   (valid_out),
    .result_out  (result_out)
  );
  page_zero_memory i_page_zero_memory (.addr_in(look_addr), .data_out(look_data));

  // Free-running clock.
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // ==========================================================================
  // Compare and report tasks
  // ==========================================================================
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Compares a word; case inequality so an unknown never matches.
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Compares a single flag.
  task automatic check_flag(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  // ==========================================================================
  // Drivers
  // ==========================================================================
  // Sends one instruction; bit_data comes from the memory model.
  // The answer stands right after the taking edge and is checked 1 ns later.
  task automatic issue(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
                       input logic [7:0] ix, input logic [15:0] pc, input logic cond);
    look_addr = {8'h00, b1};
    #1;
    @(posedge clk_in);
    req_in       <= '{op, b1, b2, ix, pc, cond, look_data};
    req_valid_in <= 1'b1;
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    #1;
    check_flag(valid_out, 1'b1, "valid");
  endtask

  // Checks mode, category, length and the sequential successor.
  task automatic expect_decode(input oag_pkg::mode_e m, input oag_pkg::category_e c,
                               input logic [1:0] len);
    check_word({12'h000, result_out.mode}, {12'h000, m}, "mode");
    check_word({13'h0000, result_out.category}, {13'h0000, c}, "category");
    check_word({14'h0000, result_out.length}, {14'h0000, len}, "length");
    check_word(result_out.next_pc, req_in.pc + {14'h0000, len}, "next pc");
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Inherent one-byte opcodes carry no address; the accumulator increment writes back.
  task automatic test_inherent();
    issue(8'h99, 8'h00, 8'h00, 8'h00, 16'h0010, 1'b0);
    expect_decode(oag_pkg::MODE_INH, oag_pkg::CAT_CONTROL, oag_pkg::LEN_ONE);
    check_flag(result_out.has_addr, 1'b0, "inh addr");
    issue(8'h4C, 8'h00, 8'h00, 8'h00, 16'h0011, 1'b0);
    expect_decode(oag_pkg::MODE_INH, oag_pkg::CAT_RMW, oag_pkg::LEN_ONE);
    check_flag(result_out.writeback, 1'b1, "inc wb");
    $display("inherent done");
  endtask

  // The data byte is passed on and no address is formed.
  task automatic test_immediate();
    issue(8'hA6, 8'h5A, 8'h00, 8'h00, 16'h0020, 1'b0);
    expect_decode(oag_pkg::MODE_IMM, oag_pkg::CAT_REG_MEM, oag_pkg::LEN_TWO);
    check_flag(result_out.has_imm, 1'b1, "has imm");
    check_word({8'h00, result_out.imm_data}, 16'h005A, "imm");
    check_flag(result_out.has_addr, 1'b0, "imm addr");
    $display("immediate done");
  endtask

  // Address modes, direct and 8-bit offset at their top values, the 16-bit sum wrapping.
  task automatic test_addressing();
    issue(8'hB6, 8'hFF, 8'h00, 8'h00, 16'h0030, 1'b0);
    expect_decode(oag_pkg::MODE_DIR, oag_pkg::CAT_REG_MEM, oag_pkg::LEN_TWO);
    check_word(result_out.operand_addr, 16'h00FF, "dir");
    issue(8'hC6, 8'h12, 8'h34, 8'h00, 16'h0040, 1'b0);
    expect_decode(oag_pkg::MODE_EXT, oag_pkg::CAT_REG_MEM, oag_pkg::LEN_THREE);
    check_word(result_out.operand_addr, 16'h1234, "ext");
    issue(8'hF6, 8'h00, 8'h00, 8'h80, 16'h0050, 1'b0);
    expect_decode(oag_pkg::MODE_IX, oag_pkg::CAT_REG_MEM, oag_pkg::LEN_ONE);
    check_word(result_out.operand_addr, 16'h0080, "ix");
    issue(8'hE6, 8'hFF, 8'h00, 8'hFF, 16'h0060, 1'b0);
    expect_decode(oag_pkg::MODE_IX1, oag_pkg::CAT_REG_MEM, oag_pkg::LEN_TWO);
    check_word(result_out.operand_addr, 16'h01FE, "ix1");
    issue(8'hD6, 8'hFF, 8'hF0, 8'h20, 16'h0070, 1'b0);
    expect_decode(oag_pkg::MODE_IX2, oag_pkg::CAT_REG_MEM, oag_pkg::LEN_THREE);
    check_word(result_out.operand_addr, 16'h0010, "ix2 wrap");
    $display("addressing done");
  endtask

  // Branch reach at both offset extremes, a false condition and a pc wrap.
  task automatic test_relative();
    logic [7:0]  offs [4] = '{8'h80, 8'h7F, 8'h7F, 8'h7F};
    logic [15:0] pcs [4]  = '{16'h0100, 16'h0100, 16'h0100, 16'hFFFE};
    logic        conds [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    logic [15:0] dests [4] = '{16'h0082, 16'h0181, 16'h0102, 16'h007F};
    for (int i = 0; i < 4; i++) begin
      issue(8'h20, offs[i], 8'h00, 8'h00, pcs[i], conds[i]);
      expect_decode(oag_pkg::MODE_REL, oag_pkg::CAT_JUMP_BRANCH, oag_pkg::LEN_TWO);
      check_flag(result_out.take_branch, conds[i], "take");
      check_word(result_out.branch_pc, dests[i], "rel dest");
    end
    $display("relative done");
  endtask

  // Bit tests: taken on set, not taken on set, taken on clear.
  task automatic test_bit_branch();
    logic [7:0] ops [3] = '{8'h00, 8'h02, 8'h03};
    logic [7:0] mem_byte;
    logic       tbit;
    mem_byte = 8'h40 ^ 8'hA5;
    for (int i = 0; i < 3; i++) begin
      tbit = mem_byte[ops[i][3:1]];
      issue(ops[i], 8'h40, 8'h10, 8'h00, 16'h0200, 1'b0);
      expect_decode(oag_pkg::MODE_BIT_BRANCH, oag_pkg::CAT_BIT_MANIP, oag_pkg::LEN_THREE);
      check_word(result_out.operand_addr, 16'h0040, "bit addr");
      check_flag(result_out.carry_load, 1'b1, "c load");
      check_flag(result_out.carry, tbit, "carry");
      check_flag(result_out.take_branch, tbit ^ ops[i][0], "bit take");
      check_word(result_out.branch_pc, (tbit ^ ops[i][0]) ? 16'h0213 : 16'h0203, "bit dest");
    end
    $display("bit branch done");
  endtask

  // Category and write-back over a spread of opcodes, the test column included.
  task automatic test_categories();
    logic [7:0] ops [6] = '{8'h10, 8'h3D, 8'h3C, 8'h80, 8'hBC, 8'hA6};
    logic [2:0] cats [6] = '{3'h3, 3'h1, 3'h1, 3'h4, 3'h2, 3'h0};
    logic       wbs [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 6; i++) begin
      issue(ops[i], 8'h44, 8'h00, 8'h00, 16'h0300, 1'b0);
      check_word({13'h0000, result_out.category}, {13'h0000, cats[i]}, "cat");
      check_flag(result_out.writeback, wbs[i], "wb");
    end
    $display("categories done");
  endtask

  // Two requests on consecutive edges, then the result must hold.
  task automatic test_back_to_back();
    @(posedge clk_in);
    req_in       <= '{8'hB6, 8'h11, 8'h00, 8'h00, 16'h0400, 1'b0, 8'h00};
    req_valid_in <= 1'b1;
    @(posedge clk_in);
    req_in       <= '{8'hC6, 8'hAB, 8'hCD, 8'h00, 16'h0402, 1'b0, 8'h00};
    #1;
    check_word(result_out.operand_addr, 16'h0011, "first");
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    #1;
    check_flag(valid_out, 1'b1, "second valid");
    check_word(result_out.operand_addr, 16'hABCD, "second");
    @(posedge clk_in);
    #1;
    check_flag(valid_out, 1'b0, "pulse end");
    check_word(result_out.operand_addr, 16'hABCD, "hold");
    // A reset in mid-run clears the held result.
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    @(posedge clk_in);
    rst_b_in <= 1'b1;
    #1;
    check_flag(|result_out, 1'b0, "reset clears");
    $display("back to back done");
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    num_errors   = 0;
    num_checks   = 0;
    rst_b_in     = 1'b0;
    req_valid_in = 1'b0;
    req_in       = '0;
    look_addr    = 16'h0000;
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    #1;
    check_flag(valid_out, 1'b0, "reset valid");
    check_flag(|result_out, 1'b0, "reset result");
    test_inherent();
    test_immediate();
    test_addressing();
    test_relative();
    test_bit_branch();
    test_categories();
    test_back_to_back();
    give_verdict();
  end
endmodule
